// file: hw/adc_controller.sv
// Controller end: issues starts, captures results into a FIFO
`timescale 1ns/1ns
`include "adc_cfg.svh"
module adc_controller #(
  parameter int SLEEP_WAKE = `SLEEP_WAKE_CYCLES
) (
  input  wire logic            clock,
  input  wire logic            srst,
  adc_link_if.controller       link,
  input  wire adc_pkg::bus_mode_t mode,
  input  wire logic            run,
  input  wire logic            shutdown,
  input  wire logic            sleep_select,
  output logic                 sample_valid,
  input  wire logic            sample_ready,
  output adc_pkg::sample_t     sample_data
);
  import adc_pkg::*;

  typedef enum logic [2:0] {
    CT_OFF,
    CT_WAKE,
    CT_IDLE,
    CT_START,
    CT_WAIT,
    CT_GAP
  } ctl_state_t;

  ctl_state_t  state_q, state_d;
  logic [23:0] cnt_q, cnt_d;
  logic        busy_prev_q;
  logic        cs_n_q, cs_n_d;
  logic        strobe_n_q, strobe_n_d;
  logic        pd_n_q, pd_n_d;
  logic        slept_q, slept_d;
  logic        push;
  logic        fifo_ready;
  logic        shared;

  localparam logic [23:0] GAP_N = 24'(`THROUGHPUT_CYCLES - `CONV_CYCLES);

  // Read and start share one strobe in slow-memory and ROM modes
  assign shared = (mode == MODE_SLOW_MEMORY) || (mode == MODE_ROM);
  // Result valid on busy rising edge, captured once
  assign push = !busy_prev_q && link.busy_n;

  always_comb begin
    state_d    = state_q;
    cnt_d      = (cnt_q != '0) ? cnt_q - 24'h000001 : cnt_q;
    cs_n_d     = 1'b0;
    strobe_n_d = 1'b1;
    pd_n_d     = 1'b1;
    slept_d    = slept_q;
    unique case (state_q)
      CT_OFF: begin
        pd_n_d  = 1'b0;
        cs_n_d  = sleep_select;
        // Track a change of mode while shut down so the wake wait matches
        slept_d = sleep_select;
        if (!shutdown) begin
          state_d = CT_WAKE;
          cnt_d   = slept_q ? 24'(SLEEP_WAKE) : 24'(`NAP_WAKE_CYCLES);
        end
      end
      CT_WAKE: begin
        if (cnt_q == '0) begin
          state_d = CT_IDLE;
        end
      end
      CT_IDLE: begin
        if (shutdown) begin
          state_d = CT_OFF;
          slept_d = sleep_select;
          pd_n_d  = 1'b0;
          cs_n_d  = sleep_select;
        end else if (run && fifo_ready && link.busy_n) begin
          state_d    = CT_START;
          strobe_n_d = 1'b0;
        end
      end
      CT_START: begin
        strobe_n_d = 1'b0;
        state_d    = CT_WAIT;
      end
      CT_WAIT: begin
        // Slow memory holds strobe low as a wait state until busy rises
        strobe_n_d = !(mode == MODE_SLOW_MEMORY);
        if (push) begin
          state_d = CT_GAP;
          cnt_d   = GAP_N;
        end
      end
      CT_GAP: begin
        if (cnt_q == '0) begin
          state_d = CT_IDLE;
        end
      end
      default: state_d = CT_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q     <= CT_WAKE;
      cnt_q       <= 24'(`NAP_WAKE_CYCLES);
      busy_prev_q <= 1'b1;
      cs_n_q      <= 1'b0;
      strobe_n_q  <= 1'b1;
      pd_n_q      <= 1'b1;
      slept_q     <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      busy_prev_q <= link.busy_n;
      cs_n_q      <= cs_n_d;
      strobe_n_q  <= strobe_n_d;
      pd_n_q      <= pd_n_d;
      slept_q     <= slept_d;
    end
  end

  // Always-on mode keeps read low; shared modes tie read to start
  assign link.chip_select_n      = cs_n_q;
  assign link.power_down_n       = pd_n_q;
  assign link.conversion_start_n = strobe_n_q;
  assign link.read_n = (mode == MODE_ALWAYS_ON) ? 1'b0 :
                       shared ? strobe_n_q : !(state_q == CT_WAIT && link.busy_n);

  // FIFO fills on busy rise; full stalls further starts
  sample_fifo #(
    .WIDTH (`DATA_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .srst      (srst),
    .in_valid  (push && state_q == CT_WAIT),
    .in_ready  (fifo_ready),
    .in_data   (link.data_out),
    .out_valid (sample_valid),
    .out_ready (sample_ready),
    .out_data  (sample_data)
  );
endmodule

// file: hw/adc_cfg.svh
// Timing counts and constants shared by both ends of the converter link
`ifndef ADC_CFG_SVH
`define ADC_CFG_SVH
`define CLK_PERIOD_PS     4000
`define CONV_TYP_PS       950000
`define CONV_MAX_PS       1150000
`define ACQ_MAX_PS        300000
`define THROUGHPUT_PS     1250000
`define NAP_WAKE_PS       400000
`define SLEEP_WAKE_MS     10
// Conversion length: typical time, rounded down
`define CONV_CYCLES       (`CONV_TYP_PS / `CLK_PERIOD_PS)
`define ACQ_CYCLES        (`ACQ_MAX_PS / `CLK_PERIOD_PS)
// Least times round up
`define THROUGHPUT_CYCLES ((`THROUGHPUT_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define NAP_WAKE_CYCLES   ((`NAP_WAKE_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
// Divide first: ten milliseconds' worth of picoseconds would overflow a 32-bit integer
`define SLEEP_WAKE_CYCLES (`SLEEP_WAKE_MS * (1000000000 / `CLK_PERIOD_PS))
`define DATA_WIDTH        14
`define FIFO_DEPTH        32
`define MID_SCALE         14'h0000
`endif

// file: hw/adc_pkg.sv
// Types shared by the converter and its controller
package adc_pkg;
  typedef logic [13:0] sample_t;
  typedef enum logic [1:0] {
    MODE_ALWAYS_ON,
    MODE_SEPARATE_READ,
    MODE_SLOW_MEMORY,
    MODE_ROM
  } bus_mode_t;
  typedef enum logic [1:0] {
    PWR_ACTIVE,
    PWR_NAP,
    PWR_SLEEP
  } power_state_t;
endpackage

// file: hw/adc_link_if.sv
// Parallel pin bundle between converter and controller
`timescale 1ns/1ns
interface adc_link_if;
  logic        chip_select_n;
  logic        read_n;
  logic        conversion_start_n;
  logic        power_down_n;
  logic        busy_n;
  logic [13:0] data_out;
  logic        data_oe;

  modport converter (
    input  chip_select_n,
    input  read_n,
    input  conversion_start_n,
    input  power_down_n,
    output busy_n,
    output data_out,
    output data_oe
  );
  modport controller (
    output chip_select_n,
    output read_n,
    output conversion_start_n,
    output power_down_n,
    input  busy_n,
    input  data_out,
    input  data_oe
  );
endinterface

// file: hw/sample_fifo.sv
// Parameterised valid/ready FIFO for captured samples
`timescale 1ns/1ns
module sample_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             push, pop;

  // Honest full and empty from the occupancy count
  always_comb begin
    in_ready  = (cnt_q != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
    out_valid = (cnt_q != '0);
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wr_d      = push ? wr_q + 1'b1 : wr_q;
    rd_d      = pop ? rd_q + 1'b1 : rd_q;
    cnt_d     = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    out_data  = mem[rd_q];
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage has no reset; reads are gated by out_valid
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
endmodule

// file: hw/adc_converter.sv
// Converter end: conversion timing, busy, data port and shutdown modes
`timescale 1ns/1ns
`include "adc_cfg.svh"
module adc_converter (
  input  wire logic            clock,
  input  wire logic            srst,
  adc_link_if.converter        link,
  input  wire adc_pkg::sample_t analog_sample,
  output adc_pkg::power_state_t power_state,
  output logic                 reference_on,
  output logic                 ready_for_start
);
  import adc_pkg::*;

  typedef enum logic [1:0] {
    CV_IDLE,
    CV_CONVERT,
    CV_ACQUIRE
  } conv_state_t;

  conv_state_t  state_q, state_d;
  power_state_t pwr_q, pwr_d;
  logic [11:0]  cnt_q, cnt_d;
  logic [11:0]  wake_q, wake_d;
  logic         start_prev_q;
  sample_t      result_q, result_d;
  sample_t      hold_q, hold_d;
  logic         start_edge;
  logic         can_start;

  localparam logic [11:0] CONV_N  = 12'(`CONV_CYCLES);
  localparam logic [11:0] ACQ_N   = 12'(`ACQ_CYCLES);
  localparam logic [11:0] NAP_N   = 12'(`NAP_WAKE_CYCLES);

  // Falling edge of start only; a held-low start does not retrigger
  assign start_edge = start_prev_q && !link.conversion_start_n;
  assign can_start  = (pwr_q == PWR_ACTIVE) && (wake_q == '0) && !link.chip_select_n;

  // Power state and nap wake-up count; sleep wake is left to the controller
  always_comb begin
    pwr_d  = pwr_q;
    wake_d = (wake_q != '0) ? wake_q - 12'h001 : wake_q;
    if (!link.power_down_n) begin
      pwr_d  = link.chip_select_n ? PWR_SLEEP : PWR_NAP;
      wake_d = '0;
    end else if (pwr_q == PWR_NAP) begin
      pwr_d  = PWR_ACTIVE;
      wake_d = NAP_N;
    end else if (pwr_q == PWR_SLEEP) begin
      pwr_d  = PWR_ACTIVE;
    end
  end

  // Conversion sequencer timed from the internal clock
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    result_d = result_q;
    hold_d   = hold_q;
    unique case (state_q)
      CV_IDLE: begin
        if (start_edge && can_start) begin
          state_d = CV_CONVERT;
          hold_d  = analog_sample;
          cnt_d   = CONV_N;
        end
      end
      CV_CONVERT: begin
        cnt_d = cnt_q - 12'h001;
        if (cnt_q == 12'h001) begin
          state_d  = CV_ACQUIRE;
          result_d = hold_q;
          cnt_d    = ACQ_N;
        end
      end
      CV_ACQUIRE: begin
        cnt_d = cnt_q - 12'h001;
        if (cnt_q == 12'h001) begin
          state_d = CV_IDLE;
        end
      end
      // The fourth code is unused; fall back to idle
      default: begin
        state_d = CV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_q      <= CV_IDLE;
      pwr_q        <= PWR_ACTIVE;
      cnt_q        <= '0;
      wake_q       <= '0;
      start_prev_q <= 1'b1;
      result_q     <= `MID_SCALE;
      hold_q       <= `MID_SCALE;
    end else begin
      state_q      <= state_d;
      pwr_q        <= pwr_d;
      cnt_q        <= cnt_d;
      wake_q       <= wake_d;
      start_prev_q <= link.conversion_start_n;
      result_q     <= result_d;
      hold_q       <= hold_d;
    end
  end

  // Busy low only while converting; acquisition is hidden from the host
  assign link.busy_n = (state_q != CV_CONVERT);
  // Data shows the last finished result, driven only while selected and read
  assign link.data_out = result_q;
  assign link.data_oe  = !link.chip_select_n && !link.read_n;
  assign power_state     = pwr_q;
  assign reference_on    = (pwr_q != PWR_SLEEP);
  assign ready_for_start = (state_q == CV_IDLE) && can_start;
endmodule

// file: bench/adc_link_chk.sv
// Checker for the converter link pins
`timescale 1ns/1ns
module adc_link_chk #(
  parameter int SLEEP_WAKE = 50
) (
  input wire logic        clock,
  input wire logic        srst,
  input wire logic        chip_select_n,
  input wire logic        read_n,
  input wire logic        conversion_start_n,
  input wire logic        power_down_n,
  input wire logic        busy_n,
  input wire logic [13:0] data_out,
  input wire logic        data_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  int   low_q, high_q, gap_q, wake_q;
  logic sleep_q;
  // Cycle counters; gap starts large so the first start is no short gap
  always_ff @(posedge clock) begin
    low_q   <= (srst || busy_n) ? 0 : low_q + 1;
    high_q  <= (srst || !busy_n) ? 0 : high_q + 1;
    gap_q   <= srst ? 400 : ($fell(conversion_start_n) ? 0 : gap_q + 1);
    wake_q  <= (srst || !power_down_n) ? 0 : wake_q + 1;
    sleep_q <= srst ? 1'b0 : (!power_down_n ? chip_select_n : sleep_q);
  end
  property p_start; $fell(busy_n) |-> $past(!chip_select_n && power_down_n); endproperty
  a_start: assert property (p_start) else $error("busy fell while not selected");
  property p_len; $rose(busy_n) |-> low_q == 237; endproperty
  a_len: assert property (p_len) else $error("busy low length off");
  property p_acq; $fell(busy_n) |-> high_q >= 75; endproperty
  a_acq: assert property (p_acq) else $error("acquire too short");
  property p_space; $fell(conversion_start_n) |-> gap_q >= 312; endproperty
  a_space: assert property (p_space) else $error("starts too close");
  property p_nap; $fell(busy_n) && !sleep_q |-> wake_q >= 100; endproperty
  a_nap: assert property (p_nap) else $error("start during nap wake");
  property p_sleep; $fell(conversion_start_n) && sleep_q |-> wake_q >= SLEEP_WAKE - 1; endproperty
  a_sleep: assert property (p_sleep) else $error("start during sleep wake");
  property p_pd; !busy_n |-> power_down_n; endproperty
  a_pd: assert property (p_pd) else $error("shutdown while converting");
  property p_once; !busy_n |-> !$fell(conversion_start_n); endproperty
  a_once: assert property (p_once) else $error("start while busy");
  property p_hold; !$rose(busy_n) |-> $stable(data_out); endproperty
  a_hold: assert property (p_hold) else $error("data moved off busy rise");
  property p_oe; data_oe == (!chip_select_n && !read_n); endproperty
  a_oe: assert property (p_oe) else $error("output enable wrong");
endmodule

// file: bench/adc_conversion_read_control_test.sv
// Bench: converter and controller joined by the pin bundle
`timescale 1ns/1ns
`include "adc_cfg.svh"
module adc_conversion_read_control_test;
  import adc_pkg::*;
  logic         clock = 0, srst = 1, run = 0, shutdown = 0, sleep_select = 0, sample_ready = 1, rnd = 0, bp = 1;
  logic         reference_on, ready_for_start, sample_valid;
  bus_mode_t    mode = MODE_ALWAYS_ON;
  sample_t      analog_sample = 14'h2000, sample_data, qw[$], qf[$];
  sample_t      corner[4] = '{14'h1FFF, 14'h3FFF, 14'h0000, 14'h0001};
  power_state_t power_state;
  logic [13:0]  low2 = 14'h0000;
  int           error_cnt = 0, n_compared = 0, nk = 0, seed;
  adc_link_if link();
  adc_link_if link2();
  adc_converter adc_converter_i (.clock(clock), .srst(srst), .link(link), .analog_sample(analog_sample),
    .power_state(power_state), .reference_on(reference_on), .ready_for_start(ready_for_start));
  // Second converter faces a bench driver that breaks the start rules
  adc_converter adc_converter_i2 (.clock(clock), .srst(srst), .link(link2), .analog_sample(14'h1234),
    .power_state(), .reference_on(), .ready_for_start());
  adc_controller #(.SLEEP_WAKE(50)) adc_controller_i (.clock(clock), .srst(srst), .link(link), .mode(mode),
    .run(run), .shutdown(shutdown), .sleep_select(sleep_select), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_data(sample_data));
  adc_link_chk #(.SLEEP_WAKE(50)) adc_link_chk_i (.clock(clock), .srst(srst), .chip_select_n(link.chip_select_n),
    .read_n(link.read_n), .conversion_start_n(link.conversion_start_n), .power_down_n(link.power_down_n),
    .busy_n(link.busy_n), .data_out(link.data_out), .data_oe(link.data_oe));
  always #2 clock = ~clock;
  task check(string what, logic [13:0] seen, logic [13:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [13:0] flag(logic b);
    return {13'h0, b};
  endfunction
  task summarize();
    if (error_cnt == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Analog input moves only after a result lands, so the sampled value is known
  always @(posedge clock) begin
    if (!srst) begin
      if (bp && !link.busy_n) begin
        qw.push_back(analog_sample);
        qf.push_back(analog_sample);
      end
      if (!bp && link.busy_n && qw.size() > 0) begin
        check("wire", link.data_out, qw.pop_front());
        analog_sample <= nk < 4 ? corner[nk] : 14'($urandom);
        nk++;
      end
      if (sample_valid && sample_ready) check("fifo", sample_data, qf.size() > 0 ? qf.pop_front() : 14'h0);
      if (link2.busy_n && low2 != 0) check("len2", low2, 14'(`CONV_CYCLES));
      low2 <= link2.busy_n ? 14'h0 : low2 + 14'h1;
      if (rnd) sample_ready <= 1'($urandom);
    end
    bp <= link.busy_n;
  end
  // Fault driver: deselected start, narrow high pulse, restart mid-conversion
  initial begin
    link2.chip_select_n = 1;
    link2.read_n = 1;
    link2.conversion_start_n = 1;
    link2.power_down_n = 1;
    repeat (200) @(posedge clock);
    link2.conversion_start_n <= 0;
    repeat (5) @(posedge clock);
    check("desel", flag(link2.busy_n), 14'h1);
    check("oe off", flag(link2.data_oe), 14'h0);
    link2.chip_select_n <= 0;
    link2.read_n <= 0;
    repeat (3) @(posedge clock);
    check("oe on", flag(link2.data_oe), 14'h1);
    link2.conversion_start_n <= 1;
    @(posedge clock);
    link2.conversion_start_n <= 0;
    repeat (60) @(posedge clock);
    check("busy2", flag(link2.busy_n), 14'h0);
    link2.conversion_start_n <= 1;
    @(posedge clock);
    link2.conversion_start_n <= 0;
  end
  // Watchdog: a normal run takes about 24k cycles
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end
  initial begin
    seed = $urandom(32'h3FCA);
    repeat (2) @(posedge clock);
    srst <= 0;
    rnd <= 1;
    // Every bus mode with random consumer stalls
    for (int m = 0; m < 4; m++) begin
      mode <= bus_mode_t'(m);
      run <= 1;
      repeat (1600) @(posedge clock);
      run <= 0;
      repeat (400) @(posedge clock);
    end
    // Consumer stops until the FIFO refuses, then drains
    rnd <= 0;
    // Let the random stall driver stop before taking over the ready line
    @(posedge clock);
    sample_ready <= 0;
    run <= 1;
    repeat (12520) @(posedge clock);
    check("full", flag(qf.size() >= 32 && qf.size() <= 33), 14'h1);
    sample_ready <= 1;
    repeat (400) @(posedge clock);
    run <= 0;
    repeat (400) @(posedge clock);
    check("empty", flag(sample_valid), 14'h0);
    // Nap then sleep, conversions after each exit
    for (int s = 0; s < 2; s++) begin
      sleep_select <= s[0];
      shutdown <= 1;
      repeat (20) @(posedge clock);
      check("pstate", flag(power_state == (s ? PWR_SLEEP : PWR_NAP)), 14'h1);
      check("ref", flag(reference_on), flag(s == 0));
      check("rfs off", flag(ready_for_start), 14'h0);
      shutdown <= 0;
      run <= 1;
      repeat (800) @(posedge clock);
      check("awake", flag(power_state == PWR_ACTIVE), 14'h1);
      run <= 0;
      repeat (400) @(posedge clock);
      check("rfs on", flag(ready_for_start), 14'h1);
    end
    summarize();
  end
endmodule
